// ### rtl/tpo_pkg.sv
// constants and register map of the timer, prescaler and option control block
//
// Overview of operation
// - The option register is read/write and every bit goes to one on any reset.
// - The option register answers at both mirrored addresses with one shared storage.
// - Bit 7 high turns all port B pull-ups off, low lets each latch bit enable its pull-up.
// - Bit 6 picks the external interrupt edge: one for rising, zero for falling.
// - Bit 5 picks the timer count source: one for the count pin, zero for the cycle clock.
// - Bit 4 picks the count pin edge: one for high-to-low, zero for low-to-high.
// - Bit 3 gives the one prescaler to the watchdog when one, to the timer when zero, never both.
// - Bits 2 to 0 set the timer ratio from 1:2 at code 000, doubling per code.
// - With the prescaler on the watchdog the timer counts every source event.
package tpo_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [9:0] CFG_IDX        = 10'h081;
  localparam logic [9:0] CFG_MIRROR_IDX = 10'h181;
  localparam logic [9:0] CNT_IDX        = 10'h000;
  localparam logic [9:0] STAT_IDX       = 10'h001;
  localparam logic [9:0] MASK_IDX       = 10'h002;
  localparam logic [9:0] LATCH_IDX      = 10'h003;

  // ==========================================================
  // option register fields
  localparam logic [7:0] CFG_RESET      = 8'hFF;
  localparam int         PULLUP_DIS_BIT = 7;
  localparam int         IRQ_EDGE_BIT   = 6;
  localparam int         CLK_SRC_BIT    = 5;
  localparam int         CNT_EDGE_BIT   = 4;
  localparam int         PS_ASSIGN_BIT  = 3;
  localparam int         RATE_MSB       = 2;
  localparam int         RATE_LSB       = 0;

  // ==========================================================
  // status and mask layout
  localparam int         STAT_W         = 3;
  localparam int         ST_T0_OVF      = 0;
  localparam int         ST_EXT_IRQ     = 1;
  localparam int         ST_WDT_TICK    = 2;
  localparam logic [2:0] STAT_RESET     = 3'h0;
  localparam logic [2:0] MASK_RESET     = 3'h0;
  localparam logic [7:0] CNT_RESET      = 8'h00;
  localparam logic [7:0] CNT_MAX        = 8'hFF;
  localparam logic [7:0] LATCH_RESET    = 8'h00;

  // ==========================================================
  // bus answers and timing
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam int         CYC_DIV_DEF    = 4;

endpackage

// ### rtl/tpo_prescaler.sv
// shared prescaler counter with rate decode
`timescale 1ns/1ps

module tpo_prescaler #(
  parameter int CNT_W = 8
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [2:0] rate_code,
  input  wire logic       wdt_mode,
  output logic            out_pulse
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [3:0]       shift;
  logic [CNT_W:0]   one_hot;
  logic [CNT_W:0]   term_full;
  logic [CNT_W-1:0] term;
  logic             at_term;

  // ==========================================================
  // rate decode
  // ratio doubles per code
  assign shift     = {1'b0, rate_code} + {3'h0, ~wdt_mode};
  assign one_hot   = {{CNT_W{1'b0}}, 1'b1} << shift;
  assign term_full = one_hot - {{CNT_W{1'b0}}, 1'b1};
  assign term      = term_full[CNT_W-1:0];
  assign at_term   = (cnt_r == term);
  assign out_pulse = tick & at_term;

  // ==========================================================
  // counter
  assign cnt_nxt = clear     ? '0 :
                   out_pulse ? '0 :
                   tick      ? cnt_r + 1'b1 : cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ### rtl/tpo_top.sv
// timer clock source, shared prescaler, edge selects and option register behind axi4-lite
`timescale 1ns/1ps

module tpo_top #(
  parameter int CYC_DIV = tpo_pkg::CYC_DIV_DEF,
  parameter int PS_W    = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins and neighbours
  input  wire logic        ext_count_pin,
  input  wire logic        ext_irq_pin,
  input  wire logic        watchdog_timer_tick,
  output logic [7:0]       port_b_pullup_en,
  output logic             watchdog_scaled_tick,
  output logic             irq
);

  // ==========================================================
  // declarations
  logic [7:0]                 cfg_r;
  logic [7:0]                 timer_zero_counter_r;
  logic [tpo_pkg::STAT_W-1:0] stat_r;
  logic [tpo_pkg::STAT_W-1:0] stat_nxt;
  logic [tpo_pkg::STAT_W-1:0] mask_r;
  logic [7:0]                 latch_r;
  logic [7:0]                 cnt_nxt;

  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [9:0]  aw_idx_r;
  logic [7:0]  wbyte_r;
  logic        wlane_r;

  logic        cnt_s1_r;
  logic        cnt_s2_r;
  logic        cnt_s3_r;
  logic        irq_s1_r;
  logic        irq_s2_r;
  logic        irq_s3_r;

  logic [7:0]  cyc_cnt_r;
  logic        irq_r;
  logic [7:0]  pullup_r;
  logic        wdt_out_r;

  // ==========================================================
  // option fields
  logic       port_b_pins_pullup_disable;
  logic       ext_irq_edge_select;
  logic       count_clock_source_select;
  logic       count_edge_select;
  logic       prescaler_assign;
  logic [2:0] prescale_rate_select;

  assign port_b_pins_pullup_disable      = cfg_r[tpo_pkg::PULLUP_DIS_BIT];
  assign ext_irq_edge_select       = cfg_r[tpo_pkg::IRQ_EDGE_BIT];
  assign count_clock_source_select = cfg_r[tpo_pkg::CLK_SRC_BIT];
  assign count_edge_select         = cfg_r[tpo_pkg::CNT_EDGE_BIT];
  assign prescaler_assign          = cfg_r[tpo_pkg::PS_ASSIGN_BIT];
  assign prescale_rate_select      = cfg_r[tpo_pkg::RATE_MSB:tpo_pkg::RATE_LSB];

  // ==========================================================
  // write channel handshake
  logic aw_take;
  logic w_take;
  logic wr_commit;
  logic aw_hold_nxt;
  logic w_hold_nxt;
  logic bvalid_nxt;

  assign aw_take     = s_axi_awvalid & awready_r;
  assign w_take      = s_axi_wvalid & wready_r;
  // commit only once the previous response is gone
  assign wr_commit   = aw_hold_r & w_hold_r & ~bvalid_r;
  assign aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_commit;
  assign w_hold_nxt  = (w_hold_r | w_take) & ~wr_commit;
  assign bvalid_nxt  = wr_commit | (bvalid_r & ~s_axi_bready);

  // ==========================================================
  // write decode
  logic wr_cfg;
  logic wr_cnt;
  logic wr_stat;
  logic wr_mask;
  logic wr_latch;
  logic wr_hit;
  logic wr_en;

  assign wr_en    = wr_commit & wlane_r;
  assign wr_cfg   = (aw_idx_r == tpo_pkg::CFG_IDX) | (aw_idx_r == tpo_pkg::CFG_MIRROR_IDX);
  assign wr_cnt   = aw_idx_r == tpo_pkg::CNT_IDX;
  assign wr_stat  = aw_idx_r == tpo_pkg::STAT_IDX;
  assign wr_mask  = aw_idx_r == tpo_pkg::MASK_IDX;
  assign wr_latch = aw_idx_r == tpo_pkg::LATCH_IDX;
  assign wr_hit   = wr_cfg | wr_cnt | wr_stat | wr_mask | wr_latch;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= tpo_pkg::RESP_OKAY;
      aw_idx_r  <= '0;
      wbyte_r   <= '0;
      wlane_r   <= 1'b0;
    end else begin
      awready_r <= ~aw_hold_nxt;
      wready_r  <= ~w_hold_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        aw_idx_r <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_commit) begin
        bresp_r <= wr_hit ? tpo_pkg::RESP_OKAY : tpo_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // read channel
  logic        ar_take;
  logic        rvalid_nxt;
  logic [9:0]  ar_idx;
  logic        rd_cfg;
  logic        rd_hit;
  logic [31:0] rd_mux;

  assign ar_take    = s_axi_arvalid & arready_r;
  assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
  assign ar_idx     = s_axi_araddr[11:2];
  assign rd_cfg     = (ar_idx == tpo_pkg::CFG_IDX) | (ar_idx == tpo_pkg::CFG_MIRROR_IDX);
  assign rd_hit     = rd_cfg | (ar_idx == tpo_pkg::CNT_IDX) | (ar_idx == tpo_pkg::STAT_IDX) |
                      (ar_idx == tpo_pkg::MASK_IDX) | (ar_idx == tpo_pkg::LATCH_IDX);
  assign rd_mux     = rd_cfg                         ? {24'h000000, cfg_r} :
                      (ar_idx == tpo_pkg::CNT_IDX)   ? {24'h000000, timer_zero_counter_r} :
                      (ar_idx == tpo_pkg::STAT_IDX)  ? {29'h0, stat_r} :
                      (ar_idx == tpo_pkg::MASK_IDX)  ? {29'h0, mask_r} :
                      (ar_idx == tpo_pkg::LATCH_IDX) ? {24'h000000, latch_r} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= tpo_pkg::RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? tpo_pkg::RESP_OKAY : tpo_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_s1_r <= 1'b0;
      cnt_s2_r <= 1'b0;
      cnt_s3_r <= 1'b0;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
      irq_s3_r <= 1'b0;
    end else begin
      cnt_s1_r <= ext_count_pin;
      cnt_s2_r <= cnt_s1_r;
      cnt_s3_r <= cnt_s2_r;
      irq_s1_r <= ext_irq_pin;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
    end
  end

  // ==========================================================
  // edge detection
  logic cnt_rise;
  logic cnt_fall;
  logic irq_rise;
  logic irq_fall;
  logic pin_count_evt;
  logic ext_irq_evt;

  assign cnt_rise      = cnt_s2_r & ~cnt_s3_r;
  assign cnt_fall      = ~cnt_s2_r & cnt_s3_r;
  assign irq_rise      = irq_s2_r & ~irq_s3_r;
  assign irq_fall      = ~irq_s2_r & irq_s3_r;
  assign pin_count_evt = count_edge_select ? cnt_fall : cnt_rise;
  assign ext_irq_evt   = ext_irq_edge_select ? irq_rise : irq_fall;

  // ==========================================================
  // instruction-cycle enable
  logic cyc_en;

  assign cyc_en = (cyc_cnt_r == 8'(CYC_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_cnt_r <= 8'h00;
    end else begin
      cyc_cnt_r <= cyc_en ? 8'h00 : cyc_cnt_r + 8'h01;
    end
  end

  // ==========================================================
  // prescaler routing
  logic src_evt;
  logic ps_tick;
  logic ps_out;
  logic ps_clear;
  logic t0_inc;
  logic wdt_evt;

  assign src_evt  = count_clock_source_select ? pin_count_evt : cyc_en;
  assign ps_tick  = prescaler_assign ? watchdog_timer_tick : src_evt;
  // reassignment or a counter write restarts the division
  assign ps_clear = (wr_en & wr_cfg & (wbyte_r[tpo_pkg::PS_ASSIGN_BIT] != prescaler_assign)) |
                    (wr_en & wr_cnt);
  assign t0_inc   = prescaler_assign ? src_evt : ps_out;
  assign wdt_evt  = prescaler_assign ? ps_out : watchdog_timer_tick;

  tpo_prescaler #(
    .CNT_W     (PS_W)
  ) u_prescaler (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (ps_clear),
    .tick      (ps_tick),
    .rate_code (prescale_rate_select),
    .wdt_mode  (prescaler_assign),
    .out_pulse (ps_out)
  );

  // ==========================================================
  // timer counter and events
  logic t0_ovf;
  logic [tpo_pkg::STAT_W-1:0] evt_vec;
  logic [tpo_pkg::STAT_W-1:0] w1c_vec;

  // a software load takes priority over a same-cycle count
  assign t0_ovf  = t0_inc & ~(wr_en & wr_cnt) & (timer_zero_counter_r == tpo_pkg::CNT_MAX);
  assign cnt_nxt = (wr_en & wr_cnt) ? wbyte_r :
                   t0_inc           ? timer_zero_counter_r + 8'h01 : timer_zero_counter_r;

  assign evt_vec[tpo_pkg::ST_T0_OVF]   = t0_ovf;
  assign evt_vec[tpo_pkg::ST_EXT_IRQ]  = ext_irq_evt;
  assign evt_vec[tpo_pkg::ST_WDT_TICK] = wdt_evt;
  assign w1c_vec  = (wr_en & wr_stat) ? wbyte_r[tpo_pkg::STAT_W-1:0] : '0;
  // new events win over a clear in the same cycle
  assign stat_nxt = (stat_r & ~w1c_vec) | evt_vec;

  // ==========================================================
  // storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r                <= tpo_pkg::CFG_RESET;
      timer_zero_counter_r <= tpo_pkg::CNT_RESET;
      stat_r               <= tpo_pkg::STAT_RESET;
      mask_r               <= tpo_pkg::MASK_RESET;
      latch_r              <= tpo_pkg::LATCH_RESET;
    end else begin
      if (wr_en & wr_cfg) begin
        cfg_r <= wbyte_r;
      end
      if (wr_en & wr_mask) begin
        mask_r <= wbyte_r[tpo_pkg::STAT_W-1:0];
      end
      if (wr_en & wr_latch) begin
        latch_r <= wbyte_r;
      end
      timer_zero_counter_r <= cnt_nxt;
      stat_r               <= stat_nxt;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r     <= 1'b0;
      pullup_r  <= 8'h00;
      wdt_out_r <= 1'b0;
    end else begin
      irq_r     <= |(stat_nxt & mask_r);
      pullup_r  <= port_b_pins_pullup_disable ? 8'h00 : latch_r;
      wdt_out_r <= wdt_evt;
    end
  end

  assign s_axi_awready        = awready_r;
  assign s_axi_wready         = wready_r;
  assign s_axi_bvalid         = bvalid_r;
  assign s_axi_bresp          = bresp_r;
  assign s_axi_arready        = arready_r;
  assign s_axi_rvalid         = rvalid_r;
  assign s_axi_rdata          = rdata_r;
  assign s_axi_rresp          = rresp_r;
  assign port_b_pullup_en     = pullup_r;
  assign watchdog_scaled_tick = wdt_out_r;
  assign irq                  = irq_r;

endmodule

// ### sim/tpo_pins.sv
// external count pin and interrupt pin model
`timescale 1ns/1ps

module tpo_pins (
  input  wire logic aclk,
  output logic      ext_count_pin,
  output logic      ext_irq_pin
);
  initial begin
    ext_count_pin = 1'b0;
    ext_irq_pin   = 1'b0;
  end

  // ==========================================================
  // level changes
  // each level held past the two-stage synchroniser and edge detect
  task automatic set_cnt(input logic v);
    @(posedge aclk);
    ext_count_pin <= v;
    repeat (5) @(posedge aclk);
  endtask

  task automatic set_irq(input logic v);
    @(posedge aclk);
    ext_irq_pin <= v;
    repeat (5) @(posedge aclk);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      set_cnt(1'b1);
      set_cnt(1'b0);
    end
  endtask
endmodule

// ### sim/tpo_chk.sv
// concurrent checks on the option control block ports
`timescale 1ns/1ps

module tpo_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        watchdog_timer_tick,
  input wire logic        watchdog_scaled_tick,
  input wire logic [7:0]  port_b_pullup_en,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // bus steps
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ==========================================================
  // assertions
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && port_b_pullup_en == 8'h00)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (s_wr_both |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_addr_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second address taken before commit");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while read pending");
  a_wdt_cause: assert property (watchdog_scaled_tick |-> $past(watchdog_timer_tick))
    else $error("scaled watchdog tick without raw tick");
endmodule

bind tpo_top tpo_chk tpo_chk_inst (.*);

// ### sim/test_timer0_prescaler_option_control.sv
// self-checking bench for the option control block
`timescale 1ns/1ps

module test_timer0_prescaler_option_control;
  localparam logic [11:0] A_CNT  = {tpo_pkg::CNT_IDX, 2'h0};
  localparam logic [11:0] A_STAT = {tpo_pkg::STAT_IDX, 2'h0};
  localparam logic [11:0] A_MASK = {tpo_pkg::MASK_IDX, 2'h0};
  localparam logic [11:0] A_LAT  = {tpo_pkg::LATCH_IDX, 2'h0};
  localparam logic [11:0] A_CFG  = {tpo_pkg::CFG_IDX, 2'h0};
  localparam logic [11:0] A_MIR  = {tpo_pkg::CFG_MIRROR_IDX, 2'h0};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        ext_count_pin, ext_irq_pin, watchdog_timer_tick, watchdog_scaled_tick, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  port_b_pullup_en;
  int          error_cnt, compares, sc_cnt;

  tpo_top tpo_top_inst (.*);
  tpo_pins tpo_pins_inst (.aclk(aclk), .ext_count_pin(ext_count_pin), .ext_irq_pin(ext_irq_pin));

  always #20 aclk = ~aclk;
  always @(posedge aclk) if (watchdog_scaled_tick === 1'b1) sc_cnt <= sc_cnt + 1;

  // ==========================================================
  // common tasks
  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic got;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    got = 1'b0;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        got = 1'b1;
        rsp = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
    if (!got) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    logic got;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    got = 1'b0;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        rsp = s_axi_rresp;
        rd_v = s_axi_rdata;
      end
    end
    s_axi_rready <= 1'b0;
    if (!got) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, rd_v);
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge aclk);
      watchdog_timer_tick <= 1'b1;
      @(posedge aclk);
      watchdog_timer_tick <= 1'b0;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    chk("pullup", 32'h0, 32'(port_b_pullup_en));
    rdc(A_CFG, 32'h000000FF, "cfg_reset");
    rdc(A_MIR, 32'h000000FF, "mirror_reset");
    wr(A_MIR, 32'h00000000);
    rdc(A_CFG, 32'h00000000, "cfg_via_mirror");
    wr(A_CFG, 32'h5A5A5AA5);
    chk("bresp", 32'(tpo_pkg::RESP_OKAY), 32'(rsp));
    rdc(A_MIR, 32'h000000A5, "mirror_via_cfg");
    do_reset();
    rdc(A_CFG, 32'h000000FF, "cfg_rereset");
    chk("rresp_ok", 32'(tpo_pkg::RESP_OKAY), 32'(rsp));
    // lane 0 strobe off: the write is answered but not stored
    s_axi_wstrb <= 4'hE;
    wr(A_CFG, 32'h00000011);
    s_axi_wstrb <= 4'hF;
    chk("bresp_lane_off", 32'(tpo_pkg::RESP_OKAY), 32'(rsp));
    rdc(A_CFG, 32'h000000FF, "cfg_lane_off");
    rdc(12'h7FC, 32'h0, "unmapped_data");
    chk("rresp", 32'(tpo_pkg::RESP_SLVERR), 32'(rsp));
    wr(12'h7FC, 32'h00000000);
    chk("bresp_unmapped", 32'(tpo_pkg::RESP_SLVERR), 32'(rsp));
  endtask

  task automatic t_pullup;
    wr(A_LAT, 32'h000000A5);
    repeat (3) @(posedge aclk);
    chk("pullup_off", 32'h0, 32'(port_b_pullup_en));
    wr(A_CFG, 32'h0000007F);
    repeat (3) @(posedge aclk);
    chk("pullup_on", 32'h000000A5, 32'(port_b_pullup_en));
    wr(A_LAT, 32'h0000003C);
    repeat (3) @(posedge aclk);
    chk("pullup_latch", 32'h0000003C, 32'(port_b_pullup_en));
    wr(A_CFG, 32'h000000FF);
    repeat (3) @(posedge aclk);
    chk("pullup_off2", 32'h0, 32'(port_b_pullup_en));
  endtask

  task automatic t_irq;
    wr(A_MASK, 32'h00000002);
    wr(A_CFG, 32'h000000C8);
    tpo_pins_inst.set_irq(1'b1);
    rdc(A_STAT, 32'h00000002, "stat_rise");
    chk("irq_rise", 32'h1, 32'(irq));
    wr(A_STAT, 32'h00000002);
    rdc(A_STAT, 32'h0, "stat_clear");
    chk("irq_clear", 32'h0, 32'(irq));
    tpo_pins_inst.set_irq(1'b0);
    rdc(A_STAT, 32'h0, "stat_fall_ignored");
    wr(A_CFG, 32'h00000088);
    tpo_pins_inst.set_irq(1'b1);
    rdc(A_STAT, 32'h0, "stat_rise_ignored");
    tpo_pins_inst.set_irq(1'b0);
    rdc(A_STAT, 32'h00000002, "stat_fall");
    chk("irq_fall", 32'h1, 32'(irq));
    wr(A_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_masked", 32'h0, 32'(irq));
    wr(A_STAT, 32'h00000007);
  endtask

  task automatic t_edge;
    for (int e = 0; e < 2; e++) begin
      tpo_pins_inst.set_cnt(1'b1);
      wr(A_CFG, 32'h000000AF | (e << 4));
      wr(A_CNT, 32'h0);
      tpo_pins_inst.set_cnt(1'b0);
      rdc(A_CNT, 32'(e), "cnt_fall");
      tpo_pins_inst.set_cnt(1'b1);
      rdc(A_CNT, 32'h1, "cnt_rise");
    end
    tpo_pins_inst.set_cnt(1'b0);
    wr(A_CFG, 32'h00000088);
    wr(A_CNT, 32'h0);
    repeat (40) @(posedge aclk);
    rd(A_CNT);
    chk("cnt_internal", 32'h1, 32'(rd_v >= 9 && rd_v <= 12));
  endtask

  task automatic t_prescale;
    for (int n = 0; n < 8; n++) begin
      wr(A_CFG, 32'h000000A0 | n);
      wr(A_CNT, 32'h0);
      tpo_pins_inst.pulses(2 << (n + 1));
      rdc(A_CNT, 32'h2, "cnt_scaled");
    end
  endtask

  task automatic t_wdt;
    for (int n = 0; n < 8; n++) begin
      wr(A_CFG, 32'h00000080 | n);
      wr(A_CFG, 32'h00000088 | n);
      sc_cnt = 0;
      ticks(2 << n);
      repeat (3) @(posedge aclk);
      chk("wdt_scaled", 32'h2, 32'(sc_cnt));
    end
    wr(A_CFG, 32'h00000087);
    sc_cnt = 0;
    ticks(5);
    repeat (3) @(posedge aclk);
    chk("wdt_raw", 32'h5, 32'(sc_cnt));
  endtask

  task automatic t_ovf;
    wr(A_CFG, 32'h00000088);
    wr(A_CNT, 32'h0);
    wr(A_STAT, 32'h00000007);
    wr(A_CNT, 32'h000000FF);
    repeat (8) @(posedge aclk);
    rdc(A_STAT, 32'h00000001, "stat_ovf");
    wr(A_MASK, 32'h00000001);
    repeat (2) @(posedge aclk);
    chk("irq_ovf", 32'h1, 32'(irq));
  endtask

  initial begin
    aclk                = 1'b0;
    aresetn             = 1'b0;
    s_axi_awaddr        = 12'h000;
    s_axi_awvalid       = 1'b0;
    s_axi_wdata         = 32'h0;
    s_axi_wstrb         = 4'hF;
    s_axi_wvalid        = 1'b0;
    s_axi_bready        = 1'b0;
    s_axi_araddr        = 12'h000;
    s_axi_arvalid       = 1'b0;
    s_axi_rready        = 1'b0;
    watchdog_timer_tick = 1'b0;
    do_reset();
    t_regs();
    t_pullup();
    t_irq();
    t_edge();
    t_prescale();
    t_wdt();
    t_ovf();
    end_of_test();
  end
endmodule
